// file: src/pdc_defines.vh
`ifndef PDC_DEFINES_VH
`define PDC_DEFINES_VH

// ------------------------------------------------------------
// serial frame layout
// ------------------------------------------------------------
`define PDC_FRAME_BITS   16
`define PDC_CNT_W        5
`define PDC_OP_MSB       15
`define PDC_OP_LSB       12
`define PDC_DATA_MSB     7
`define PDC_DATA_LSB     0

// ------------------------------------------------------------
// serial opcodes
// ------------------------------------------------------------
`define PDC_OP_NOP       4'h0
`define PDC_OP_FAULT_MASK_REG_ZERO     4'h1
`define PDC_OP_FAULT_MASK_REG_ONE     4'h2
`define PDC_OP_CLR_INT   4'h3

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define PDC_MASK_RST     8'h00
`define PDC_DEAD_W       8
`define PDC_DEAD_ZERO    8'h00
`define PDC_SYNC_RST     17'h0_19C4

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define PDC_RST_MAX_NS   77
`define PDC_CLK_NS       100

`endif

// file: src/pdc_top.v
`timescale 1ns/1ps
`include "pdc_defines.vh"
// What this block does
// - gate drives may turn on only while both enables are high.
// - enable gating acts without waiting on any command timing.
// - after enables return, each high side stays off until its low side has been on.
// - reset pin low disables all outputs, low power, resets logic.
// - high-side command inputs are active low, idle off.
// - low-side command inputs are active high, idle off.
// - dead time and interlock keep one phase's two drivers apart.
// - before logic supply is good, hold reset, float drives, refuse serial.
// - unmasked fault raises interrupt until the clear command.
// - each fault is maskable through one of two mask registers.
// - serial activity counts only while chip select is low.
// - serial input sampled on falling clock edges, msb first.
// - serial output floats while deselected, changes on rising edges.
// - phase level flag follows its half-supply comparator.
// - overcurrent flag follows the overcurrent comparator.
module pdc_top #(
    parameter FAULT_W = 16
) (
    input  wire                   sys_clk,
    input  wire                   sys_rst,
    input  wire                   logic_supply_ok,
    input  wire                   chip_reset_n,
    input  wire                   drive_enable_first,
    input  wire                   drive_enable_second,
    input  wire                   phase_a_high_cmd_n,
    input  wire                   phase_a_low_cmd,
    input  wire                   phase_b_high_cmd_n,
    input  wire                   phase_b_low_cmd,
    input  wire                   phase_c_high_cmd_n,
    input  wire                   phase_c_low_cmd,
    input  wire [2:0]             phase_cmp,
    input  wire                   overcurrent_cmp,
    input  wire [FAULT_W-1:0]     fault_in,
    input  wire                   deadtime_bypass,
    input  wire                   interlock_bypass,
    input  wire [`PDC_DEAD_W-1:0] dead_cycles,
    input  wire                   spi_cs_n,
    input  wire                   spi_sclk,
    input  wire                   spi_si,
    output reg                    spi_so,
    output reg                    spi_so_oe,
    output reg  [2:0]             gate_high,
    output reg  [2:0]             gate_low,
    output reg                    gate_oe,
    output reg                    low_power,
    output reg                    irq_out,
    output reg                    phase_a_level_flag,
    output reg                    phase_b_level_flag,
    output reg                    phase_c_level_flag,
    output reg                    overcurrent_flag
);

// ------------------------------------------------------------
// constants
// ------------------------------------------------------------
localparam NPIN = 17 + FAULT_W;
localparam [`PDC_CNT_W-1:0] FRAME = `PDC_FRAME_BITS;
localparam [`PDC_CNT_W-1:0] CNT_ONE = 1;
localparam integer RST_CYC_RAW = `PDC_RST_MAX_NS / `PDC_CLK_NS;
localparam integer RST_CYC = (RST_CYC_RAW < 1) ? 1 : RST_CYC_RAW;
localparam [NPIN-1:0] SYNC_RST =
    {{FAULT_W{1'b0}}, `PDC_SYNC_RST};

// ------------------------------------------------------------
// input synchronisers
// ------------------------------------------------------------
// bit order, low to high: si sclk cs_n ls[2:0] hs_n[2:0] en2 en1
// rst_n supply_ok oc cmp[2:0] faults
wire [NPIN-1:0] pins = {fault_in, phase_cmp, overcurrent_cmp,
    logic_supply_ok, chip_reset_n, drive_enable_first,
    drive_enable_second, phase_c_high_cmd_n, phase_b_high_cmd_n,
    phase_a_high_cmd_n, phase_c_low_cmd, phase_b_low_cmd,
    phase_a_low_cmd, spi_cs_n, spi_sclk, spi_si};
reg  [NPIN-1:0] meta_q;
reg  [NPIN-1:0] sync_q;

always @(posedge sys_clk) begin
    if (sys_rst) begin
        meta_q <= SYNC_RST;
        sync_q <= SYNC_RST;
    end else begin
        meta_q <= pins;
        sync_q <= meta_q;
    end
end

wire               si_s      = sync_q[0];
wire               sclk_s    = sync_q[1];
wire               cs_n_s    = sync_q[2];
wire [2:0]         ls_req    = sync_q[5:3];
wire [2:0]         hs_req    = ~sync_q[8:6];
wire               en_both   = sync_q[9] & sync_q[10];
wire               rst_n_s   = sync_q[11];
wire               sup_ok_s  = sync_q[12];
wire               oc_s      = sync_q[13];
wire [2:0]         cmp_s     = sync_q[16:14];
wire [FAULT_W-1:0] fault_s   = sync_q[NPIN-1:17];

// internal logic reset: system, reset pin or low logic supply
wire int_rst = sys_rst | ~rst_n_s | ~sup_ok_s;

// ------------------------------------------------------------
// serial port
// ------------------------------------------------------------
reg                      sclk_q;
reg                      cs_n_q;
reg  [`PDC_CNT_W-1:0]    bit_cnt_q;
reg  [FRAME-1:0]         rx_q;
reg  [FRAME-1:0]         tx_q;
reg  [7:0]               fault_mask_reg_zero_q;
reg  [7:0]               fault_mask_reg_one_q;
reg                      clr_q;

wire sclk_fall = sclk_q & ~sclk_s;
wire sclk_rise = ~sclk_q & sclk_s;
wire sel       = ~cs_n_s;
wire cs_fall   = cs_n_q & ~cs_n_s;
wire cs_rise   = ~cs_n_q & cs_n_s;
wire frame_ok  = cs_rise & (bit_cnt_q == FRAME);
wire [3:0] op  = rx_q[`PDC_OP_MSB:`PDC_OP_LSB];
wire [7:0] dat = rx_q[`PDC_DATA_MSB:`PDC_DATA_LSB];
reg  [2:0] boot_ok_q;
wire [FRAME-1:0] status = {irq_out, oc_s, cmp_s, boot_ok_q,
                           fault_s[7:0]};

always @(posedge sys_clk) begin
    if (int_rst) begin
        sclk_q    <= 1'b0;
        cs_n_q    <= 1'b1;
        bit_cnt_q <= {`PDC_CNT_W{1'b0}};
        rx_q      <= {FRAME{1'b0}};
        tx_q      <= {FRAME{1'b0}};
        fault_mask_reg_zero_q   <= `PDC_MASK_RST;
        fault_mask_reg_one_q   <= `PDC_MASK_RST;
        clr_q     <= 1'b0;
    end else begin
        sclk_q <= sclk_s;
        cs_n_q <= cs_n_s;
        clr_q  <= 1'b0;
        if (cs_fall) begin
            bit_cnt_q <= {`PDC_CNT_W{1'b0}};
            tx_q      <= status;
        end else if (sel && sclk_fall) begin
            rx_q <= {rx_q[FRAME-2:0], si_s};
            if (bit_cnt_q != FRAME)
                bit_cnt_q <= bit_cnt_q + CNT_ONE;
        end else if (sel && sclk_rise && bit_cnt_q != 0) begin
            tx_q <= {tx_q[FRAME-2:0], 1'b0};
        end
        if (frame_ok) begin
            if (op == `PDC_OP_FAULT_MASK_REG_ZERO) begin
                fault_mask_reg_zero_q <= dat;
            end else if (op == `PDC_OP_FAULT_MASK_REG_ONE) begin
                fault_mask_reg_one_q <= dat;
            end else if (op == `PDC_OP_CLR_INT) begin
                clr_q <= 1'b1;
            end
        end
    end
end

// ------------------------------------------------------------
// interrupt
// ------------------------------------------------------------
wire [FAULT_W-1:0] mask_all;
assign mask_all[7:0] = fault_mask_reg_zero_q;
generate
    if (FAULT_W > 8) begin : g_hi
        assign mask_all[FAULT_W-1:8] = fault_mask_reg_one_q[FAULT_W-9:0];
    end
endgenerate
wire fault_hit = |(fault_s & ~mask_all);

// ------------------------------------------------------------
// gate drive: enables, bootstrap order, interlock, dead time
// ------------------------------------------------------------
reg [`PDC_DEAD_W-1:0] hi_off_q [0:2];
reg [`PDC_DEAD_W-1:0] lo_off_q [0:2];
reg [2:0]             hi_d;
reg [2:0]             lo_d;
reg [2:0]             boot_d;
integer               i;

function dead_done;
    input [`PDC_DEAD_W-1:0] cnt;
    input [`PDC_DEAD_W-1:0] lim;
    input                   byp;
    begin
        dead_done = byp | (cnt >= lim);
    end
endfunction

always @* begin
    hi_d   = 3'b000;
    lo_d   = 3'b000;
    boot_d = boot_ok_q;
    for (i = 0; i < 3; i = i + 1) begin
        if (!en_both) begin
            boot_d[i] = 1'b0;
        end else if (gate_low[i]) begin
            boot_d[i] = 1'b1;
        end
        if (en_both) begin
            if (interlock_bypass || !(hs_req[i] && ls_req[i])) begin
                hi_d[i] = hs_req[i] & boot_ok_q[i] &
                    dead_done(lo_off_q[i], dead_cycles,
                              deadtime_bypass);
                lo_d[i] = ls_req[i] &
                    dead_done(hi_off_q[i], dead_cycles,
                              deadtime_bypass);
            end
        end
    end
end

always @(posedge sys_clk) begin
    if (int_rst) begin
        for (i = 0; i < 3; i = i + 1) begin
            hi_off_q[i] <= `PDC_DEAD_ZERO;
            lo_off_q[i] <= `PDC_DEAD_ZERO;
        end
        boot_ok_q <= 3'b000;
    end else begin
        boot_ok_q <= boot_d;
        for (i = 0; i < 3; i = i + 1) begin
            if (gate_high[i])
                hi_off_q[i] <= `PDC_DEAD_ZERO;
            else if (hi_off_q[i] != {`PDC_DEAD_W{1'b1}})
                hi_off_q[i] <= hi_off_q[i] + 1'b1;
            if (gate_low[i])
                lo_off_q[i] <= `PDC_DEAD_ZERO;
            else if (lo_off_q[i] != {`PDC_DEAD_W{1'b1}})
                lo_off_q[i] <= lo_off_q[i] + 1'b1;
        end
    end
end

// ------------------------------------------------------------
// output registers
// ------------------------------------------------------------
always @(posedge sys_clk) begin
    if (int_rst) begin
        gate_high          <= 3'b000;
        gate_low           <= 3'b000;
        gate_oe            <= 1'b0;
        spi_so             <= 1'b0;
        spi_so_oe          <= 1'b0;
        irq_out            <= 1'b0;
        phase_a_level_flag <= 1'b0;
        phase_b_level_flag <= 1'b0;
        phase_c_level_flag <= 1'b0;
        overcurrent_flag   <= 1'b0;
        low_power          <= ~rst_n_s & ~sys_rst;
    end else begin
        gate_high          <= hi_d;
        gate_low           <= lo_d;
        gate_oe            <= 1'b1;
        spi_so             <= tx_q[FRAME-1];
        spi_so_oe          <= sel;
        irq_out            <= fault_hit | (irq_out & ~clr_q);
        phase_a_level_flag <= cmp_s[0];
        phase_b_level_flag <= cmp_s[1];
        phase_c_level_flag <= cmp_s[2];
        overcurrent_flag   <= oc_s;
        low_power          <= 1'b0;
    end
end

endmodule // pdc_top

// file: testbench/pdc_monitor.sv
`timescale 1ns/1ps
module pdc_monitor #(
    parameter FAULT_W = 16
) (
    input wire       sys_clk,
    input wire       sys_rst,
    input wire       logic_supply_ok,
    input wire       chip_reset_n,
    input wire       drive_enable_first,
    input wire       drive_enable_second,
    input wire       overcurrent_cmp,
    input wire       interlock_bypass,
    input wire       deadtime_bypass,
    input wire [7:0] dead_cycles,
    input wire       spi_cs_n,
    input wire       spi_so_oe,
    input wire [2:0] gate_high,
    input wire [2:0] gate_low,
    input wire       gate_oe,
    input wire       low_power,
    input wire       irq_out,
    input wire       overcurrent_flag
);
    // ----
    // boot tracking
    // ----
    logic boot_q;
    wire  en_all = drive_enable_first & drive_enable_second;
    wire  live   = chip_reset_n & logic_supply_ok;
    always @(posedge sys_clk) begin
        if (sys_rst || !en_all) begin
            boot_q <= 1'b0;
        end else if (gate_low[0]) begin
            boot_q <= 1'b1;
        end
    end
    // ----
    // checks
    // ----
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    en_gate_a: assert property (
        (!en_all) [*4] |-> (gate_high | gate_low) == 3'h0)
        else $error("gate on while disabled");
    no_shoot_a: assert property (
        !interlock_bypass |-> (gate_high & gate_low) == 3'h0)
        else $error("both sides on");
    dead_gap_a: assert property (
        !deadtime_bypass && dead_cycles == 8'h05 && $fell(gate_low[0])
        |-> (!gate_high[0]) [*4]) else $error("dead time short");
    rst_pin_a: assert property (
        (!chip_reset_n) [*4] |-> low_power && !gate_oe && !irq_out)
        else $error("reset pin ignored");
    por_off_a: assert property (
        (!logic_supply_ok) [*4] |-> !gate_oe && !spi_so_oe)
        else $error("active before supply good");
    so_float_a: assert property (
        spi_cs_n [*4] |-> !spi_so_oe) else $error("serial out driven");
    oc_follow_a: assert property (
        (overcurrent_cmp && live) [*4] |-> overcurrent_flag)
        else $error("overcurrent flag low");
    irq_hold_a: assert property (
        (spi_cs_n && live) [*8] ##0 irq_out |=> irq_out)
        else $error("interrupt dropped");
    boot_first_a: assert property (
        $rose(gate_high[0]) |-> boot_q) else $error("high before low");
    cover property ($rose(irq_out));
    cover property ($rose(gate_high[0]));
    cover property ($fell(spi_cs_n));
endmodule // pdc_monitor

bind pdc_top pdc_monitor #(.FAULT_W(FAULT_W)) mon (.*);

// file: testbench/pdc_host_model.sv
`timescale 1ns/1ps
module pdc_host_model (
    output logic spi_cs_n,
    output logic spi_sclk,
    output logic spi_si,
    input  wire  spi_so
);
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_si   = 1'b0;
    end
    // one 16-bit frame, 800 ns link period
    task automatic frame(input logic [15:0] w, output logic [15:0] rd);
        int i;
        rd = 16'h0000;
        #130;
        spi_cs_n = 1'b0;
        #400;
        for (i = 15; i >= 0; i--) begin
            spi_sclk = 1'b1;
            spi_si   = w[i];
            #400;
            spi_sclk = 1'b0;
            rd = {rd[14:0], spi_so};
            #400;
        end
        spi_si = 1'b0;
        #400;
        spi_cs_n = 1'b1;
        #1000;
    endtask
endmodule // pdc_host_model

// file: testbench/pdc_top_tb.sv
`timescale 1ns/1ps
`define PDC_CHK(a, b, m) begin n_compared++; if ((a) !== (b)) begin \
    error_cnt++; $display("mismatch t=%0t %s", $time, m); end end
module pdc_top_tb;
    logic        sys_clk, sys_rst = 1'b1;
    logic        logic_supply_ok = 1'b1, chip_reset_n = 1'b1;
    logic        drive_enable_first = 1'b0, drive_enable_second = 1'b0;
    logic        phase_a_high_cmd_n = 1'b1, phase_a_low_cmd = 1'b0;
    logic        phase_b_high_cmd_n = 1'b1, phase_b_low_cmd = 1'b0;
    logic        phase_c_high_cmd_n = 1'b1, phase_c_low_cmd = 1'b0;
    logic [2:0]  phase_cmp = 3'h0;
    logic        overcurrent_cmp = 1'b0;
    logic        deadtime_bypass = 1'b0, interlock_bypass = 1'b0;
    logic [15:0] fault_in = 16'h0000;
    logic [7:0]  dead_cycles = 8'h05;
    wire         spi_cs_n, spi_sclk, spi_si, spi_so, spi_so_oe;
    wire [2:0]   gate_high, gate_low;
    wire         gate_oe, low_power, irq_out, overcurrent_flag;
    wire         phase_a_level_flag, phase_b_level_flag, phase_c_level_flag;
    int          error_cnt = 0, n_compared = 0, cycles = 0, i;
    logic [15:0] rd;
    // en, hs_n, ls, cmp, oc | expected high, low
    logic [17:0] rows [8] = '{18'h3E040, 18'h3C000, 18'h3FC07,
        18'h3E000, 18'h302B8, 18'h31D00, 18'h10000, 18'h30000};
    pdc_top #(.FAULT_W(16)) uut (.*);
    pdc_host_model host (.*);
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 8000) begin
            error_cnt++;
            summarize();
        end
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic pulse(input int b);
        @(posedge sys_clk);
        fault_in[b] <= 1'b1;
        repeat (5) @(posedge sys_clk);
        fault_in[b] <= 1'b0;
        wait_clk(5);
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (i = 0; i < 8; i++) begin
            @(posedge sys_clk);
            {drive_enable_first, drive_enable_second} <= rows[i][17:16];
            {phase_c_high_cmd_n, phase_b_high_cmd_n,
                phase_a_high_cmd_n} <= rows[i][15:13];
            {phase_c_low_cmd, phase_b_low_cmd,
                phase_a_low_cmd} <= rows[i][12:10];
            {phase_cmp, overcurrent_cmp} <= rows[i][9:6];
            wait_clk(10);
            `PDC_CHK(gate_high, rows[i][5:3], "high")
            `PDC_CHK(gate_low, rows[i][2:0], "low")
            `PDC_CHK({phase_c_level_flag, phase_b_level_flag,
                phase_a_level_flag}, rows[i][9:7], "level")
            `PDC_CHK(overcurrent_flag, rows[i][6], "oc")
        end
        $display("test table done");
        chip_reset_n <= 1'b0;
        wait_clk(4);
        `PDC_CHK({low_power, gate_oe, gate_high}, 5'h10, "rst")
        chip_reset_n <= 1'b1;
        logic_supply_ok <= 1'b0;
        wait_clk(4);
        `PDC_CHK({low_power, gate_oe, spi_so_oe}, 3'h0, "por")
        logic_supply_ok <= 1'b1;
        wait_clk(4);
        `PDC_CHK(gate_oe, 1'b1, "oe")
        $display("test reset done");
        pulse(0);
        host.frame(16'h0000, rd);
        `PDC_CHK({rd[15], irq_out}, 2'h3, "irq held")
        host.frame(16'h3000, rd);
        `PDC_CHK(irq_out, 1'b0, "irq clear")
        host.frame(16'h1001, rd);
        host.frame(16'h2001, rd);
        pulse(0);
        pulse(8);
        `PDC_CHK(irq_out, 1'b0, "masked")
        pulse(9);
        `PDC_CHK(irq_out, 1'b1, "unmasked")
        host.frame(16'h3000, rd);
        `PDC_CHK({irq_out, spi_so_oe}, 2'h0, "idle")
        $display("test interrupt done");
        summarize();
    end
endmodule // pdc_top_tb
